// [hdl/enc_sup_pkg.sv]
// Constants, register map and command codes of the encoder supervision block
package enc_sup_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ARG = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_SLIP = 8'h10;
  localparam logic [7:0] OFF_MODE = 8'h14;
  localparam logic [7:0] OFF_QUERY = 8'h18;
  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_AX_LSB = 8;
  localparam int CMD_AX_W = 4;
  localparam int ARG_ENC_LSB = 0;
  localparam int ARG_MOT_LSB = 16;
  localparam int QUERY_VALID_BIT = 8;
  // Widths and reset values
  localparam int POS_W = 32;
  localparam int TOL_W = 15;
  localparam int RATIO_W = 16;
  localparam int ACC_W = 17;
  localparam logic [31:0] TOL_MAX = 32'h0000_7FFF;
  localparam logic [15:0] RATIO_RESET = 16'h0001;
  // Query characters
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_SLIP = 8'h53;
  localparam logic [7:0] CH_NONE = 8'h4E;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Command codes, taken in declaration order from zero
  typedef enum logic [7:0] {
    OP_SLIP_KILL_ON, OP_SLIP_KILL_OFF, OP_SLIP_ARM, OP_SLIP_QUERY, OP_HOLD_OFF,
    OP_HOLD_ON, OP_FOLLOW, OP_SCALING, OP_TOLERANCE, OP_INDEX_HOME, OP_SWITCH_HOME,
    OP_LEVEL_HIGH, OP_LEVEL_LOW, OP_HOME_SEEK, OP_HOME_REVERSE, OP_HOME_VAR_A,
    OP_HOME_VAR_B, OP_LOAD_POS, OP_HALT_EVERY, OP_HALT, OP_KILL_ALL
  } opcode_t;
endpackage

// [hdl/enc_sup_ctrl.sv]
// Per-axis encoder slip, tracking and home supervision with AXI4-Lite registers
`timescale 1ns/10ps
// Summary of operation
// - With kill on, excess slip flushes queue, terminates motion, drops position hold.
// - Reset leaves kill enabled on servo axes, disabled on stepper axes.
// - Kill acts only after detection is armed by the arm command.
// - Kill off clears kill on stepper axes only, never on servo axes.
// - Armed slip or a refused command raises the interrupt when its enable bit is set.
// - Load, home seek and reverse, halt, kill commands or a limit drop hold and detection.
// - Slip query returns S or N per axis framed by LF CR pairs.
// - Hold off disables hold, slip detection and tracking on that axis.
// - Tracking copies encoder input as motion with no ramps.
// - Tracking scales encoder counts to motor steps by the set ratio.
// - Index home needs index, phase A high, phase B low, home input low.
// - Index home fixes home input active low; level commands are refused.
// - Switch home is reset default; home input level is selectable.
// - Tolerance per axis up to 32767; slip flagged when error exceeds it.
module enc_sup_ctrl
  import enc_sup_pkg::*;
#(
  parameter int NUM_AXES = 4,
  parameter logic [NUM_AXES-1:0] SERVO_MASK = '0
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [7:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic [NUM_AXES*enc_sup_pkg::POS_W-1:0] I_CMD_POS,
  input wire logic [NUM_AXES*enc_sup_pkg::POS_W-1:0] I_ENC_POS,
  input wire logic [NUM_AXES-1:0] I_ENC_A,
  input wire logic [NUM_AXES-1:0] I_ENC_B,
  input wire logic [NUM_AXES-1:0] I_ENC_INDEX,
  input wire logic [NUM_AXES-1:0] I_ENC_STEP,
  input wire logic [NUM_AXES-1:0] I_ENC_DIR,
  input wire logic [NUM_AXES-1:0] I_HOME_SW,
  input wire logic [NUM_AXES-1:0] I_LIMIT,
  output logic [NUM_AXES-1:0] O_FLUSH,
  output logic [NUM_AXES-1:0] O_TERMINATE,
  output logic [NUM_AXES-1:0] O_HOLD_EN,
  output logic [NUM_AXES-1:0] O_SLIP_ARMED,
  output logic [NUM_AXES-1:0] O_TRACK_EN,
  output logic [NUM_AXES-1:0] O_TRACK_STEP,
  output logic [NUM_AXES-1:0] O_TRACK_DIR,
  output logic [NUM_AXES-1:0] O_HOMING,
  output logic [NUM_AXES-1:0] O_HOME_FOUND,
  output logic O_IRQ
);
  import enc_sup_pkg::*;

  localparam int NA = NUM_AXES;
  localparam int AXW = (NA > 1) ? $clog2(NA) : 1;
  localparam int NI = NA + 1;
  localparam logic [3:0] Q_LAST = 4'(NA + 3);

  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] arg;
    logic [NA:0] irq_stat;
    logic [NA:0] irq_mask;
    logic [NA-1:0] kill_en;
    logic [NA-1:0] armed;
    logic [NA-1:0] hold;
    logic [NA-1:0] track;
    logic [NA-1:0] idx_mode;
    logic [NA-1:0] lvl_high;
    logic [NA-1:0] homing;
    logic [NA-1:0] slip;
    logic [NA-1:0] flush;
    logic [NA-1:0] term;
    logic [NA-1:0] found;
    logic [NA-1:0] step;
    logic [NA-1:0] dir;
    logic [NA-1:0][TOL_W-1:0] tol;
    logic [NA-1:0][RATIO_W-1:0] r_enc;
    logic [NA-1:0][RATIO_W-1:0] r_mot;
    logic [NA-1:0][ACC_W-1:0] acc;
    logic qbusy;
    logic [3:0] qidx;
  } state_t;

  state_t s;
  state_t n;

  // Bus readiness: one write and one read in flight at a time
  assign O_AWREADY = !s.aw_full && !s.bvalid;
  assign O_WREADY = !s.w_full && !s.bvalid;
  assign O_ARREADY = !s.rvalid;
  assign O_BVALID = s.bvalid;
  assign O_BRESP = s.bresp;
  assign O_RVALID = s.rvalid;
  assign O_RDATA = s.rdata;
  assign O_RRESP = s.rresp;
  assign O_FLUSH = s.flush;
  assign O_TERMINATE = s.term;
  assign O_HOLD_EN = s.hold;
  assign O_SLIP_ARMED = s.armed;
  assign O_TRACK_EN = s.track;
  assign O_TRACK_STEP = s.step;
  assign O_TRACK_DIR = s.dir;
  assign O_HOMING = s.homing;
  assign O_HOME_FOUND = s.found;
  assign O_IRQ = |(s.irq_stat & s.irq_mask);

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    logic [NA:0] ev;
    logic [NA:0] clr;
    logic [POS_W:0] diff;
    logic [POS_W-1:0] mag;
    logic det;
    logic [ACC_W-1:0] sum;
    logic [7:0] op;
    logic [CMD_AX_W-1:0] ax_full;
    logic [AXW-1:0] ax;
    logic ax_ok;
    logic [7:0] ch;
    n = s;
    ev = '0;
    clr = '0;
    diff = '0;
    mag = '0;
    det = 1'b0;
    sum = '0;
    op = '0;
    ax_full = '0;
    ax = '0;
    ax_ok = 1'b0;
    ch = '0;
    n.flush = '0;
    n.term = '0;
    n.found = '0;
    n.step = '0;

    // Axis supervision, evaluated every cycle
    for (int a = 0; a < NA; a++) begin
      diff = {I_CMD_POS[a*POS_W+POS_W-1], I_CMD_POS[a*POS_W +: POS_W]} -
             {I_ENC_POS[a*POS_W+POS_W-1], I_ENC_POS[a*POS_W +: POS_W]};
      mag = diff[POS_W] ? POS_W'(-diff) : diff[POS_W-1:0];
      if (s.armed[a] && mag > {{(POS_W-TOL_W){1'b0}}, s.tol[a]}) begin
        n.slip[a] = 1'b1;
        n.armed[a] = 1'b0;
        ev[a] = 1'b1;
        if (s.kill_en[a]) begin
          n.flush[a] = 1'b1;
          n.term[a] = 1'b1;
          n.hold[a] = 1'b0;
          n.homing[a] = 1'b0;
        end
      end
      // A limit drops hold and detection
      if (I_LIMIT[a]) begin
        n.hold[a] = 1'b0;
        n.armed[a] = 1'b0;
        n.homing[a] = 1'b0;
      end
      // Home condition per selected mode
      if (s.idx_mode[a]) begin
        det = I_ENC_INDEX[a] && I_ENC_A[a] && !I_ENC_B[a] && !I_HOME_SW[a];
      end else begin
        det = (I_HOME_SW[a] == s.lvl_high[a]);
      end
      if (s.homing[a] && det) begin
        n.found[a] = 1'b1;
        n.homing[a] = 1'b0;
      end
      // Ratio accumulator: encoder steps add motor counts, motor steps drain encoder counts
      if (s.track[a]) begin
        sum = s.acc[a] + (I_ENC_STEP[a] ? ACC_W'(s.r_mot[a]) : '0);
        if (s.r_enc[a] != '0 && sum >= ACC_W'(s.r_enc[a])) begin
          n.step[a] = 1'b1;
          n.dir[a] = I_ENC_DIR[a];
          sum = sum - ACC_W'(s.r_enc[a]);
        end
        n.acc[a] = sum;
      end
    end

    // Write address and data are taken independently
    if (I_AWVALID && O_AWREADY) begin
      n.aw_full = 1'b1;
      n.aw_addr = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      n.w_full = 1'b1;
      n.w_data = I_WDATA;
      n.w_strb = I_WSTRB;
    end
    if (s.bvalid && I_BREADY) begin
      n.bvalid = 1'b0;
    end

    // Commit a write once both halves are held
    if (s.aw_full && s.w_full) begin
      n.aw_full = 1'b0;
      n.w_full = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case ({s.aw_addr[7:2], 2'b00})
        OFF_ARG: n.arg = merge(s.arg, s.w_data, s.w_strb);
        OFF_IRQ_STAT: clr = s.w_strb[0] ? s.w_data[NA:0] : '0;
        OFF_IRQ_MASK: n.irq_mask = NI'(merge(32'(s.irq_mask), s.w_data, s.w_strb));
        OFF_CMD: begin
          if (s.w_strb[0]) begin
            op = s.w_data[CMD_OP_LSB +: 8];
            ax_full = s.w_data[CMD_AX_LSB +: CMD_AX_W];
            ax_ok = 32'(ax_full) < NA;
            ax = AXW'(ax_full);
            if (!ax_ok && op != OP_SLIP_QUERY && op != OP_HALT_EVERY && op != OP_KILL_ALL) begin
              ev[NA] = 1'b1;
            end else begin
              case (op)
                OP_SLIP_KILL_ON: n.kill_en[ax] = 1'b1;
                OP_SLIP_KILL_OFF: n.kill_en[ax] = n.kill_en[ax] & SERVO_MASK[ax];
                OP_SLIP_ARM: begin
                  n.armed[ax] = 1'b1;
                  n.slip[ax] = 1'b0;
                end
                OP_SLIP_QUERY: begin
                  n.qbusy = 1'b1;
                  n.qidx = '0;
                end
                OP_HOLD_OFF: begin
                  n.hold[ax] = 1'b0;
                  n.armed[ax] = 1'b0;
                  n.track[ax] = 1'b0;
                end
                OP_HOLD_ON: n.hold[ax] = 1'b1;
                OP_FOLLOW: begin
                  n.track[ax] = 1'b1;
                  n.acc[ax] = '0;
                end
                OP_SCALING: begin
                  n.r_enc[ax] = s.arg[ARG_ENC_LSB +: RATIO_W];
                  n.r_mot[ax] = s.arg[ARG_MOT_LSB +: RATIO_W];
                end
                OP_TOLERANCE: begin
                  if (s.arg > TOL_MAX) begin
                    ev[NA] = 1'b1;
                  end else begin
                    n.tol[ax] = s.arg[TOL_W-1:0];
                  end
                end
                OP_INDEX_HOME: n.idx_mode[ax] = 1'b1;
                OP_SWITCH_HOME: n.idx_mode[ax] = 1'b0;
                OP_LEVEL_HIGH, OP_LEVEL_LOW: begin
                  if (s.idx_mode[ax]) begin
                    ev[NA] = 1'b1;
                  end else begin
                    n.lvl_high[ax] = (op == OP_LEVEL_HIGH);
                  end
                end
                OP_HOME_SEEK, OP_HOME_REVERSE: begin
                  n.homing[ax] = 1'b1;
                  n.hold[ax] = 1'b0;
                  n.armed[ax] = 1'b0;
                end
                OP_HOME_VAR_A, OP_HOME_VAR_B: n.homing[ax] = 1'b1;
                OP_LOAD_POS: begin
                  n.hold[ax] = 1'b0;
                  n.armed[ax] = 1'b0;
                end
                OP_HALT: begin
                  n.hold[ax] = 1'b0;
                  n.armed[ax] = 1'b0;
                  n.homing[ax] = 1'b0;
                  n.term[ax] = 1'b1;
                end
                OP_HALT_EVERY, OP_KILL_ALL: begin
                  n.hold = '0;
                  n.armed = '0;
                  n.homing = '0;
                  n.term = '1;
                  n.flush = (op == OP_KILL_ALL) ? '1 : n.flush;
                end
                default: ev[NA] = 1'b1;
              endcase
            end
          end
        end
        default: n.bresp = RESP_SLVERR;
      endcase
    end

    // Sticky events: a set in the clearing cycle wins
    n.irq_stat = (s.irq_stat & ~clr) | ev;

    // Read path; reading the query register consumes one character
    if (s.rvalid && I_RREADY) begin
      n.rvalid = 1'b0;
    end
    if (I_ARVALID && O_ARREADY) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      case ({I_ARADDR[7:2], 2'b00})
        OFF_CMD: n.rdata = '0;
        OFF_ARG: n.rdata = s.arg;
        OFF_IRQ_STAT: n.rdata = 32'(s.irq_stat);
        OFF_IRQ_MASK: n.rdata = 32'(s.irq_mask);
        OFF_SLIP: n.rdata = 32'(s.slip);
        OFF_MODE: n.rdata = 32'({s.homing, s.lvl_high, s.idx_mode, s.track, s.hold,
                                 s.armed, s.kill_en});
        OFF_QUERY: begin
          if (s.qbusy) begin
            if (s.qidx == 4'h0 || s.qidx == Q_LAST - 4'h1) begin
              ch = CH_LF;
            end else if (s.qidx == 4'h1 || s.qidx == Q_LAST) begin
              ch = CH_CR;
            end else begin
              ch = s.slip[AXW'(s.qidx - 4'h2)] ? CH_SLIP : CH_NONE;
            end
            n.rdata = 32'(ch);
            n.rdata[QUERY_VALID_BIT] = 1'b1;
            n.qidx = s.qidx + 4'h1;
            n.qbusy = (s.qidx != Q_LAST);
          end
        end
        default: n.rresp = RESP_SLVERR;
      endcase
    end
  end

  // State register; servo axes start with kill enabled
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      s <= '0;
      s.kill_en <= SERVO_MASK;
      for (int a = 0; a < NA; a++) begin
        s.r_enc[a] <= RATIO_RESET;
        s.r_mot[a] <= RATIO_RESET;
      end
    end else begin
      s <= n;
    end
  end
endmodule

// [tb/enc_sup_sva.sv]
// Port checker of the encoder supervision block
`timescale 1ns/10ps
module enc_sup_sva #(
  parameter int NUM_AXES = 4
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic [NUM_AXES-1:0] I_LIMIT,
  input wire logic O_BVALID,
  input wire logic [NUM_AXES-1:0] O_FLUSH,
  input wire logic [NUM_AXES-1:0] O_TERMINATE,
  input wire logic [NUM_AXES-1:0] O_HOLD_EN,
  input wire logic [NUM_AXES-1:0] O_SLIP_ARMED,
  input wire logic [NUM_AXES-1:0] O_TRACK_EN,
  input wire logic [NUM_AXES-1:0] O_TRACK_STEP,
  input wire logic [NUM_AXES-1:0] O_HOMING,
  input wire logic [NUM_AXES-1:0] O_HOME_FOUND,
  input wire logic O_IRQ
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);
  // A write has just committed; allows for a registered output one edge late
  sequence s_cmd;
    O_BVALID || $past(O_BVALID);
  endsequence
  // Some armed axis has just been disarmed
  sequence s_trip;
    |($past(O_SLIP_ARMED) & ~O_SLIP_ARMED);
  endsequence
  property p_kill_acts;
    (O_FLUSH & (~O_TERMINATE | O_HOLD_EN | O_SLIP_ARMED)) == '0;
  endproperty
  a_kill_acts: assert property (p_kill_acts) else $error("flush without stop");
  property p_flush_pulse;
    |O_FLUSH |=> (O_FLUSH & $past(O_FLUSH)) == '0;
  endproperty
  a_flush_pulse: assert property (p_flush_pulse) else $error("long flush");
  property p_kill_cause;
    |O_FLUSH |-> s_trip or s_cmd;
  endproperty
  a_kill_cause: assert property (p_kill_cause) else $error("flush unarmed");
  property p_limit;
    |I_LIMIT |=> ($past(I_LIMIT) & (O_HOLD_EN | O_SLIP_ARMED)) == '0;
  endproperty
  a_limit: assert property (p_limit) else $error("hold kept at limit");
  property p_home;
    |O_HOME_FOUND |-> (O_HOME_FOUND & (O_HOMING | ~$past(O_HOMING))) == '0;
  endproperty
  a_home: assert property (p_home) else $error("home outside homing");
  property p_track;
    |O_TRACK_STEP |-> (O_TRACK_STEP & ~$past(O_TRACK_EN)) == '0;
  endproperty
  a_track: assert property (p_track) else $error("step without tracking");
  property p_rearm;
    |(O_SLIP_ARMED & ~$past(O_SLIP_ARMED)) |-> s_cmd;
  endproperty
  a_rearm: assert property (p_rearm) else $error("self re-arm");
  property p_irq;
    $rose(O_IRQ) |-> s_cmd or s_trip;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule
bind enc_sup_ctrl enc_sup_sva #(.NUM_AXES(NUM_AXES)) u_sva (.I_CLK(I_CLK), .I_NRST(I_NRST),
  .I_LIMIT(I_LIMIT), .O_BVALID(O_BVALID), .O_FLUSH(O_FLUSH), .O_TERMINATE(O_TERMINATE),
  .O_HOLD_EN(O_HOLD_EN), .O_SLIP_ARMED(O_SLIP_ARMED), .O_TRACK_EN(O_TRACK_EN),
  .O_TRACK_STEP(O_TRACK_STEP), .O_HOMING(O_HOMING), .O_HOME_FOUND(O_HOME_FOUND),
  .O_IRQ(O_IRQ));

// [tb/axis_model.sv]
// Axis-side model: positions, quadrature and encoder counts
`timescale 1ns/10ps
module axis_model #(
  parameter int N = 4
) (
  input wire logic i_clk,
  input wire logic [N-1:0] i_big,
  input wire logic [N-1:0] i_edge,
  input wire logic [N-1:0] i_quad,
  input wire logic [N-1:0] i_pulse,
  output logic [N*32-1:0] o_cmd,
  output logic [N*32-1:0] o_enc,
  output logic [N-1:0] o_a,
  output logic [N-1:0] o_b,
  output logic [N-1:0] o_idx,
  output logic [N-1:0] o_step
);
  // Encoder ahead by 10 or behind by 5, so both signs of error are seen
  always_comb begin
    for (int a = 0; a < N; a++) begin
      o_cmd[a*32+:32] = 32'h100 * a;
      o_enc[a*32+:32] = o_cmd[a*32+:32] + (i_big[a] ? 32'hA : 32'h0) - (i_edge[a] ? 32'h5 : 32'h0);
    end
  end
  // Home quadrant: phase A high, phase B low, index high
  assign o_a = i_quad;
  assign o_b = ~i_quad;
  assign o_idx = i_quad;
  // Count pulses leave on the clock, one cycle each
  always_ff @(posedge i_clk) o_step <= i_pulse;
endmodule

// [tb/enc_sup_ctrl_tb.sv]
// Self-checking testbench of the encoder supervision block
`timescale 1ns/10ps
module enc_sup_ctrl_tb;
  import enc_sup_pkg::*;
  localparam int N = 4;
  localparam logic [N-1:0] SERVO = 4'h3;
  localparam logic [7:0] QCH [8] = '{CH_LF, CH_CR, CH_NONE, CH_NONE, CH_SLIP, CH_SLIP, CH_LF, CH_CR};
  localparam opcode_t DROP [7] = '{OP_LOAD_POS, OP_HOME_SEEK, OP_HOME_REVERSE, OP_HALT_EVERY,
    OP_HALT, OP_KILL_ALL, OP_HOLD_OFF};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  logic [N*32-1:0] cmdp, encp;
  logic [N-1:0] big = '0, edg = '0, quad = '0, pulse = '0, hsw = '0, lim = '0;
  logic [N-1:0] ea, eb, eidx, estep, flush, term, hold, armed, tren, trst, homing, found;
  int n_mismatch = 0, tests_run = 0, n_flush = 0, n_found = 0, n_step = 0;
  always #2 clk = ~clk;
  enc_sup_ctrl #(.NUM_AXES(N), .SERVO_MASK(SERVO)) dut (.I_CLK(clk), .I_NRST(nrst),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr), .I_WVALID(wvalid),
    .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(4'hF), .O_BVALID(bvalid), .I_BREADY(bready),
    .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr),
    .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp), .I_CMD_POS(cmdp),
    .I_ENC_POS(encp), .I_ENC_A(ea), .I_ENC_B(eb), .I_ENC_INDEX(eidx), .I_ENC_STEP(estep),
    .I_ENC_DIR({N{1'b1}}), .I_HOME_SW(hsw), .I_LIMIT(lim), .O_FLUSH(flush), .O_TERMINATE(term),
    .O_HOLD_EN(hold), .O_SLIP_ARMED(armed), .O_TRACK_EN(tren), .O_TRACK_STEP(trst),
    .O_TRACK_DIR(), .O_HOMING(homing), .O_HOME_FOUND(found), .O_IRQ(irq));
  axis_model #(.N(N)) partner (.i_clk(clk), .i_big(big), .i_edge(edg), .i_quad(quad),
    .i_pulse(pulse), .o_cmd(cmdp), .o_enc(encp), .o_a(ea), .o_b(eb), .o_idx(eidx),
    .o_step(estep));
  // Pulse counters; sampled mid-cycle, where registered pulses are settled
  always @(negedge clk) begin
    n_flush += $countones(flush);
    n_found += found[1];
    n_step += trst[3];
  end
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic tmo(input bit hung);
    if (hung) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // Address and data offered together, each released once taken
  // Handshakes are judged mid-cycle, where readies are settled, and acted on at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic done, ta, tw;
    n = 0;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 50) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    #1;
    tmo(!done);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    logic done, ta;
    n = 0;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 50) begin
      @(negedge clk);
      ta = arvalid && arready;
      done = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    #1;
    tmo(!done);
  endtask
  task automatic cmd(input opcode_t op, input logic [3:0] ax);
    wr(OFF_CMD, {20'h0, ax, op});
  endtask
  task automatic t_reset();
    rd(OFF_MODE);
    chk("mode", d, {28'h0, SERVO});
    rd(8'h1C);
    chk("bad read", r, RESP_SLVERR);
    wr(8'h1C, 32'h1);
    chk("bad write", r, RESP_SLVERR);
    cmd(OP_SLIP_KILL_ON, 2);
    cmd(OP_SLIP_KILL_OFF, 0);
    rd(OFF_MODE);
    chk("servo kill", d[3:0], 4'h7);
    cmd(OP_SLIP_KILL_OFF, 2);
    rd(OFF_MODE);
    chk("stepper kill", d[3:0], 4'h3);
    cmd(OP_SLIP_KILL_ON, 2);
    $display("reset and kill test done");
  endtask
  task automatic t_slip();
    int i;
    wr(OFF_IRQ_MASK, 32'h4);
    wr(OFF_ARG, 32'h5);
    cmd(OP_TOLERANCE, 2);
    cmd(OP_TOLERANCE, 3);
    big <= 4'h4;
    idle(5);
    chk("unarmed", n_flush, 0);
    big <= 4'h0;
    edg <= 4'hC;
    cmd(OP_SLIP_ARM, 2);
    cmd(OP_SLIP_ARM, 3);
    idle(5);
    rd(OFF_MODE);
    chk("at tolerance", d[7:4], 4'hC);
    big <= 4'h4;
    edg <= 4'h8;
    idle(3);
    chk("flush", n_flush, 1);
    chk("irq", irq, 1'b1);
    wr(OFF_IRQ_STAT, 32'h4);
    chk("irq clear", irq, 1'b0);
    big <= 4'hC;
    edg <= 4'h0;
    idle(3);
    rd(OFF_SLIP);
    chk("flags", d, 32'hC);
    chk("masked", irq, 1'b0);
    chk("stepper no kill", n_flush, 1);
    rd(OFF_MODE);
    chk("stays disarmed", d[7:4], 4'h0);
    cmd(OP_SLIP_QUERY, 0);
    for (i = 0; i < 9; i++) begin
      rd(OFF_QUERY);
      chk("query", d, (i < 8) ? {23'h0, 1'b1, QCH[i]} : 32'h0);
    end
    big <= 4'h0;
    edg <= 4'h0;
    wr(OFF_IRQ_STAT, 32'h1F);
    $display("slip test done");
  endtask
  task automatic t_drop();
    for (int i = 0; i < 8; i++) begin
      cmd(OP_HOLD_ON, 2);
      cmd(OP_SLIP_ARM, 2);
      rd(OFF_MODE);
      chk("hold armed", {d[10], d[6]}, 2'h3);
      if (i < 7) cmd(DROP[i], 2);
      else lim[2] <= 1'b1;
      idle(2);
      lim[2] <= 1'b0;
      rd(OFF_MODE);
      chk("dropped", {d[10], d[6]}, 2'h0);
    end
    $display("drop test done");
  endtask
  task automatic t_home();
    cmd(OP_INDEX_HOME, 1);
    cmd(OP_LEVEL_HIGH, 1);
    rd(OFF_IRQ_STAT);
    chk("level refused", d[4], 1'b1);
    hsw[1] <= 1'b1;
    quad[1] <= 1'b1;
    cmd(OP_HOME_SEEK, 1);
    idle(4);
    chk("switch high", n_found, 0);
    hsw[1] <= 1'b0;
    idle(4);
    chk("index home", n_found, 1);
    cmd(OP_SWITCH_HOME, 1);
    cmd(OP_LEVEL_HIGH, 1);
    cmd(OP_HOME_SEEK, 1);
    idle(4);
    chk("encoder ignored", n_found, 1);
    hsw[1] <= 1'b1;
    idle(4);
    chk("switch home", n_found, 2);
    wr(OFF_IRQ_STAT, 32'h1F);
    $display("home test done");
  endtask
  task automatic t_track();
    wr(OFF_ARG, 32'h0002_0001);
    cmd(OP_SCALING, 3);
    cmd(OP_FOLLOW, 3);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) cmd(OP_HOLD_OFF, 3);
      pulse[3] <= 1'b1;
      idle(1);
      pulse[3] <= 1'b0;
      idle(6);
    end
    chk("scaled steps", n_step, 6);
    $display("tracking test done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_slip();
    t_drop();
    t_home();
    t_track();
    report_and_stop();
  end
  // Watchdog against a hung design
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
